//--- pkg/io_space_pkg.sv
// Constants and types for the I/O space access unit.
// Assumes a 32-bit address bus and a 64-bit data bus driven by one core clock.
// Notes on behaviour
// - A separate four gigabyte I/O space is reached only by I/O load and store.
// - Bus cycles from I/O instructions drive the memory select output low.
// - I/O instructions run only in supervisor mode; in user mode they are no-ops.
// - The I/O address operand goes to the bus untranslated as a physical address.
// - Memory-mapped I/O addresses are translated by paging like any memory access.
// - I/O operands never look up or allocate into the data cache.
// - A page with cache disable set is noncacheable; writes stay in order.
// - A deasserted cache enable input keeps the returned data out of the cache.
package io_space_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int SIZE_W = 2;
   localparam int PAGE_OFS_W = 12;
   localparam logic SEL_MEMORY = 1'h1;
   localparam logic SEL_IO = 1'h0;
   typedef enum {st_idle, st_bus} state_e;
endpackage : io_space_pkg

//--- logic/io_space_access_unit.sv
// Bus cycle sequencer for memory and I/O space accesses of the core.
// Assumes the core holds a request until it is accepted, and that the bus
// acknowledge and cache enable pins come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module io_space_access_unit #(
   parameter int ADDR_W = io_space_pkg::ADDR_W,
   parameter int DATA_W = io_space_pkg::DATA_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Core request
   input wire logic i_req,
   input wire logic i_req_io,
   input wire logic i_req_write,
   input wire logic i_supervisor,
   input wire logic [ADDR_W-1:0] i_req_addr,
   input wire logic [DATA_W-1:0] i_req_wdata,
   input wire logic [io_space_pkg::SIZE_W-1:0] i_req_size,
   output logic o_req_accept,
   output logic o_req_done,
   output logic o_req_noop,
   output logic [DATA_W-1:0] o_req_rdata,
   output logic o_req_cacheable,
   // Page translation for memory accesses
   input wire logic [ADDR_W-io_space_pkg::PAGE_OFS_W-1:0] i_page_frame,
   input wire logic i_page_cache_disable_bit,
   input wire logic i_cache_on,
   // Data cache lookup control
   output logic o_dcache_lookup,
   // External bus
   output logic o_bus_start,
   output logic o_bus_mem_io_sel,
   output logic o_bus_write,
   output logic [ADDR_W-1:0] o_bus_addr,
   output logic [DATA_W-1:0] o_bus_wdata,
   output logic [io_space_pkg::SIZE_W-1:0] o_bus_size,
   output logic o_bus_busy,
   input wire logic i_bus_ready,
   input wire logic [DATA_W-1:0] i_bus_rdata,
   input wire logic i_cache_enable_in_n
);

   typedef struct packed {
      io_space_pkg::state_e state;
      logic ready_s1;
      logic ready_s2;
      logic ken_s1;
      logic ken_s2;
      logic accept;
      logic done;
      logic noop;
      logic [DATA_W-1:0] rdata;
      logic cacheable;
      logic lookup;
      logic start;
      logic sel;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [io_space_pkg::SIZE_W-1:0] size;
      logic busy;
      logic may_cache;
      // Set once the synchronised ready has been seen low in this bus cycle.
      logic armed;
   } state_s;

   state_s r;
   state_s next_r;

   // Physical address: I/O bypasses paging, memory takes the page frame.
   function automatic logic [ADDR_W-1:0] phys_addr(input logic io,
         input logic [ADDR_W-1:0] va, input logic [ADDR_W-io_space_pkg::PAGE_OFS_W-1:0] frame);
      if (io) begin
         phys_addr = va;
      end else begin
         phys_addr = {frame, va[io_space_pkg::PAGE_OFS_W-1:0]};
      end
   endfunction

   always_comb begin
      next_r = r;
      next_r.ready_s1 = i_bus_ready;
      next_r.ready_s2 = r.ready_s1;
      next_r.ken_s1 = i_cache_enable_in_n;
      next_r.ken_s2 = r.ken_s1;
      next_r.accept = 1'h0;
      next_r.done = 1'h0;
      next_r.noop = 1'h0;
      next_r.start = 1'h0;
      next_r.lookup = 1'h0;
      case (r.state)
         io_space_pkg::st_idle: begin
            if (i_req && !r.accept) begin
               next_r.accept = 1'h1;
               if (i_req_io && !i_supervisor) begin
                  // User-level I/O retires with no bus cycle.
                  next_r.noop = 1'h1;
                  next_r.done = 1'h1;
                  // A dropped access must not report the verdict of an older cycle.
                  next_r.cacheable = 1'h0;
               end else begin
                  // Whole 32-bit address reaches the bus for I/O space.
                  next_r.addr = phys_addr(i_req_io, i_req_addr, i_page_frame);
                  next_r.sel = i_req_io ? io_space_pkg::SEL_IO : io_space_pkg::SEL_MEMORY;
                  next_r.lookup = !i_req_io && i_cache_on;
                  next_r.may_cache = !i_req_io && i_cache_on
                     && !i_page_cache_disable_bit;
                  // Same strobes for both spaces; only the select differs.
                  next_r.write = i_req_write;
                  next_r.wdata = i_req_wdata;
                  next_r.size = i_req_size;
                  next_r.start = 1'h1;
                  next_r.busy = 1'h1;
                  next_r.armed = 1'h0;
                  next_r.state = io_space_pkg::st_bus;
               end
            end
         end
         io_space_pkg::st_bus: begin
            // One cycle at a time in order, so noncacheable writes never reorder.
            // The synchroniser still carries the ready of the previous cycle for
            // two clocks, so a cycle started right after a done must first see
            // ready low before it may finish.
            if (!r.ready_s2) begin
               next_r.armed = 1'h1;
            end
            if (r.ready_s2 && r.armed) begin
               next_r.rdata = r.write ? '0 : i_bus_rdata;
               next_r.cacheable = !r.write && r.may_cache && !r.ken_s2;
               next_r.done = 1'h1;
               next_r.busy = 1'h0;
               next_r.sel = io_space_pkg::SEL_MEMORY;
               next_r.state = io_space_pkg::st_idle;
            end
         end
         default: begin
            next_r.state = io_space_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         r <= '0;
         r.state <= io_space_pkg::st_idle;
         r.sel <= io_space_pkg::SEL_MEMORY;
         r.ready_s1 <= 1'h0;
         r.ken_s1 <= 1'h1;
         r.ken_s2 <= 1'h1;
      end else begin
         r <= next_r;
      end
   end

   assign o_req_accept = r.accept;
   assign o_req_done = r.done;
   assign o_req_noop = r.noop;
   assign o_req_rdata = r.rdata;
   assign o_req_cacheable = r.cacheable;
   assign o_dcache_lookup = r.lookup;
   assign o_bus_start = r.start;
   assign o_bus_mem_io_sel = r.sel;
   assign o_bus_write = r.write;
   assign o_bus_addr = r.addr;
   assign o_bus_wdata = r.wdata;
   assign o_bus_size = r.size;
   assign o_bus_busy = r.busy;

endmodule // io_space_access_unit
`default_nettype wire

//--- sim/io_space_access_unit_props.sv
// Port checker for the I/O space access unit.
// Assumes default widths and one clock.
`timescale 1ns/1ps
`default_nettype none
module io_space_props(input wire logic i_clk, i_rst, i_req, i_req_io, i_supervisor,
   i_page_cache_disable_bit, i_cache_enable_in_n, o_req_accept, o_req_done, o_req_noop,
   o_req_cacheable, o_dcache_lookup, o_bus_start, o_bus_mem_io_sel, o_bus_busy,
   input wire logic [31:0] i_req_addr, o_bus_addr, input wire logic [19:0] i_page_frame);
   wire logic tk = i_req & !o_req_accept & !o_bus_busy;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   AST_SEL: assert property (tk && i_supervisor |=>
      o_bus_start && o_bus_mem_io_sel != $past(i_req_io)) else $error("select");
   AST_NOOP: assert property (tk && i_req_io && !i_supervisor |=>
      o_req_done && o_req_noop && !o_bus_start) else $error("no-op");
   AST_IO_ADDR: assert property (tk && i_req_io && i_supervisor |=>
      o_bus_addr == $past(i_req_addr)) else $error("io address");
   AST_MEM_ADDR: assert property (tk && !i_req_io |=>
      o_bus_addr == {$past(i_page_frame), $past(i_req_addr[11:0])}) else $error("address");
   AST_LOOKUP: assert property (tk && i_req_io |=> !o_dcache_lookup)
      else $error("lookup");
   AST_CD: assert property (tk && i_page_cache_disable_bit |=>
      (!o_req_done || !o_req_cacheable) [*8]) else $error("page cached");
   AST_KEN: assert property (o_req_done && $past(i_cache_enable_in_n, 3)
      && i_cache_enable_in_n |-> !o_req_cacheable) else $error("cached");
   AST_HOLD: assert property (o_bus_busy && $past(o_bus_busy) |-> $stable(o_bus_addr))
      else $error("address moved");
endmodule // io_space_props
bind io_space_access_unit io_space_props u_props(.*);
`default_nettype wire

//--- sim/io_bus_model.sv
// Far-side bus and device model.
// Assumes one bus cycle at a time, framed by busy.
`timescale 1ns/1ps
`default_nettype none
module io_bus_model(input wire logic i_clk, i_busy, input wire logic [31:0] i_addr,
   output logic o_ready, output logic [63:0] o_rdata, output logic o_ken_n);
   logic [2:0] c = 3'h0;
   always @(posedge i_clk) c <= i_busy ? c + {2'h0, c < 3'h7} : 3'h0;
   // The wait varies with the address and ready is held until the cycle ends.
   assign o_ready = i_busy && c >= {1'h0, i_addr[5:4]};
   assign o_rdata = o_ready ? {i_addr, ~i_addr} : {~i_addr, i_addr};
   assign o_ken_n = i_addr[3];
endmodule // io_bus_model
`default_nettype wire

//--- sim/io_space_access_unit_tb_top.sv
// Self-checking bench for the I/O space access unit.
// Assumes the bus model answers every bus cycle.
`timescale 1ns/1ps
`default_nettype none
module io_space_access_unit_tb_top;
   logic i_clk = 1'h0, i_rst = 1'h1, i_req = 1'h0, i_req_io = 1'h0, i_req_write = 1'h0;
   logic i_supervisor = 1'h0, i_page_cache_disable_bit = 1'h0, i_cache_on = 1'h0;
   logic [31:0] i_req_addr = 32'h0;
   logic [19:0] i_page_frame = 20'h0;
   logic [15:0] lf = 16'h9809;
   logic [63:0] i_req_wdata = 64'h0;
   logic [1:0] i_req_size = 2'h0;
   wire logic o_req_accept, o_req_done, o_req_noop, o_req_cacheable, o_dcache_lookup;
   wire logic o_bus_start, o_bus_mem_io_sel, o_bus_write, o_bus_busy, i_bus_ready;
   wire logic i_cache_enable_in_n;
   wire logic [63:0] o_req_rdata, o_bus_wdata, i_bus_rdata;
   wire logic [31:0] o_bus_addr;
   wire logic [1:0] o_bus_size;
   int mismatches = 0, num_checks = 0;
   io_space_access_unit u_dut(.*);
   io_bus_model u_bus(.i_clk(i_clk), .i_busy(o_bus_busy), .i_addr(o_bus_addr),
      .o_ready(i_bus_ready), .o_rdata(i_bus_rdata), .o_ken_n(i_cache_enable_in_n));
   always #2 i_clk = ~i_clk;
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // One access: b holds space, direction, privilege and page cache disable.
   task automatic acc(input logic [3:0] b);
      logic [31:0] ea;
      logic nop;
      int n;
      lf = nx(lf);
      nop = b[0] & !b[2];
      ea = b[0] ? {lf, ~lf} : {lf[3:0], lf, ~lf[11:0]};
      @(posedge i_clk);
      i_req <= 1'h1;
      i_req_io <= b[0];
      i_req_write <= b[1];
      i_supervisor <= b[2];
      i_page_cache_disable_bit <= b[3];
      i_cache_on <= lf[7];
      i_req_addr <= {lf, ~lf};
      i_page_frame <= {lf[3:0], lf};
      i_req_wdata <= {~lf, lf, lf, ~lf};
      i_req_size <= lf[9:8];
      @(posedge i_clk);
      i_req <= 1'h0;
      #1;
      chk(o_req_accept, 1);
      chk(o_bus_start, !nop);
      chk(o_bus_busy, !nop);
      chk(o_dcache_lookup, !b[0] & lf[7]);
      if (!nop) chk({o_bus_mem_io_sel, o_bus_addr}, {!b[0], ea});
      if (!nop) chk(o_bus_wdata, {~lf, lf, lf, ~lf});
      if (!nop) chk({o_bus_write, o_bus_size}, {b[1], lf[9:8]});
      for (n = 0; o_req_done !== 1'h1 && n < 40; n++) @(posedge i_clk) #1;
      chk(o_req_done, 1);
      chk(o_req_noop, nop);
      if (!nop && !b[1]) chk(o_req_rdata, {ea, ~ea});
      if (!nop && b[1]) chk(o_req_rdata, 0);
      chk(o_req_cacheable, !b[1] & !b[0] & lf[7] & !b[3] & !ea[3]);
   endtask
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst <= 1'h0;
      for (int i = 0; i < 80; i++) acc(i < 8 ? 4'(i) : lf[3:0]);
      complete_run;
   end
   initial begin
      #20000;
      mismatches++;
      complete_run;
   end
endmodule // io_space_access_unit_tb_top
`default_nettype wire
